// >>> t1lc_consts.vh
// constants of the t1 in-band loop code generator and detector
`ifndef T1LC_CONSTS_VH
`define T1LC_CONSTS_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define T1LC_OFS_RX_LEN_CTRL   9'h082
`define T1LC_OFS_RX_LATCHED    9'h092
`define T1LC_OFS_RX_SPARE_CTRL 9'h09b
`define T1LC_OFS_RX_SPARE_HI   9'h09c
`define T1LC_OFS_RX_SPARE_LO   9'h09d
`define T1LC_OFS_RX_IRQ_MASK   9'h0a2
`define T1LC_OFS_RX_UP_HI      9'h0ac
`define T1LC_OFS_RX_UP_LO      9'h0ad
`define T1LC_OFS_RX_DOWN_HI    9'h0ae
`define T1LC_OFS_RX_DOWN_LO    9'h0af
`define T1LC_OFS_RX_LIVE       9'h0b2
`define T1LC_OFS_TX_CTRL3      9'h183
`define T1LC_OFS_TX_CTRL4      9'h186
`define T1LC_OFS_TX_CODE_HI    9'h1ac
`define T1LC_OFS_TX_CODE_LO    9'h1ad
// ----------------------------------------
// field positions
// ----------------------------------------
`define T1LC_BIT_SEND_EN       0
`define T1LC_BIT_LEN_SEL0      0
`define T1LC_BIT_LEN_SEL1      1
`define T1LC_BIT_FBIT_OFF      2
`define T1LC_FLD_UP_LEN        2:0
`define T1LC_FLD_DOWN_LEN      5:3
`define T1LC_FLD_SPARE_LEN     2:0
`define T1LC_BIT_UP            0
`define T1LC_BIT_DOWN          1
`define T1LC_BIT_SPARE         2
`define T1LC_FLD_SET_EVT       2:0
`define T1LC_FLD_CLR_EVT       5:3
// ----------------------------------------
// reset values
// ----------------------------------------
`define T1LC_RST_REG           8'h00
// ----------------------------------------
// timing and counts
// ----------------------------------------
`define T1LC_CLK_KHZ           50000
`define T1LC_INTEG_MS          48
`define T1LC_FRAME_BITS        8'd193
`define T1LC_BLK_BITS          9'd256
`define T1LC_ERR_MAX           9'd8
`define T1LC_LEN16_M1          4'hf
`endif

// >>> t1lc_loop_code.v
// t1 in-band loop code generator and three loop code detectors
//
// What this block does
// - generator repeats a 5, 6, 7 or 16 bit pattern, only in t1 mode.
// - transmit length comes from the two length bits of tx_control_four.
// - pattern is sent while tx_code_send_enable is set and stops when clear.
// - unless disabled, one pattern bit in every 193 is replaced by the f-bit.
// - receiver has three detectors: up, down and spare.
// - up and down lengths come from the length control, spare from its own.
// - 16-bit codes join both bytes, 1-7 bit codes use the first.
// - detectors lock on framed and unframed data at error rates to 1e-2.
// - detectors lock whether the f-bit was inserted or overwrote a bit.
// - writing a detector's low code byte restarts its integration.
// - detect status sets after 48 ms of continuous valid code.
// - each detect has a live bit and latched set and clear bits.
// - a mask enables the interrupt per latched bit.
// - latched bits stay set until a one is written to them.
`include "t1lc_consts.vh"
`default_nettype none
module t1lc_loop_code #(
  parameter [31:0] INTEG_CYCLES = `T1LC_INTEG_MS * `T1LC_CLK_KHZ
) (
  input  wire       clk_sys,
  input  wire       rst,
  input  wire [8:0] regAddr,
  input  wire [7:0] regWrData,
  input  wire       regWrEn,
  input  wire       regRdEn,
  output wire [7:0] regRdData,
  output wire       irqOut,
  input  wire       t1Mode,
  input  wire       txBitEn,
  input  wire       txFbit,
  output wire       txLineBit,
  output wire       txCodeActive,
  input  wire       rxBitEn,
  input  wire       rxBit,
  input  wire       rxFbitSlot
);

  localparam [21:0] INTEG_LAST = INTEG_CYCLES[21:0] - 22'd1;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // rx select: 0..6 give 1..7 bits, 7 gives 16
  function [3:0] rxLenM1;
    input [2:0] sel;
    begin
      if (sel == 3'h7)
        rxLenM1 = `T1LC_LEN16_M1;
      else
        rxLenM1 = {1'b0, sel};
    end
  endfunction

  // tx select: 5,6,7 or 16 bits; 1,2,4,8 ride on 16
  function [3:0] txLenM1;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: txLenM1 = 4'h4;
        2'h1: txLenM1 = 4'h5;
        2'h2: txLenM1 = 4'h6;
        default: txLenM1 = `T1LC_LEN16_M1;
      endcase
    end
  endfunction

  function codeBit;
    input [15:0] code;
    input [3:0]  lenM1;
    input [3:0]  ph;
    begin
      if (lenM1 == `T1LC_LEN16_M1)
        codeBit = code[4'hf - ph];
      else
        codeBit = code[4'hf - {1'b0, ph[2:0]}];
    end
  endfunction

  function [3:0] nextPh;
    input [3:0] ph;
    input [3:0] lenM1;
    begin
      if (ph >= lenM1)
        nextPh = 4'h0;
      else
        nextPh = ph + 4'h1;
    end
  endfunction

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [7:0] lenCtrl_ff;
  reg [7:0] spareCtrl_ff;
  reg [7:0] spareHi_ff;
  reg [7:0] spareLo_ff;
  reg [7:0] upHi_ff;
  reg [7:0] upLo_ff;
  reg [7:0] downHi_ff;
  reg [7:0] downLo_ff;
  reg [7:0] irqMask_ff;
  reg [7:0] latched_ff;
  reg [7:0] txCtrl3_ff;
  reg [7:0] txCtrl4_ff;
  reg [7:0] txHi_ff;
  reg [7:0] txLo_ff;
  reg [7:0] rdData_ff;
  reg       irq_ff;
  reg [2:0] detPrev_ff;
  wire [2:0] detNow;
  wire [7:0] liveStat;
  reg  [7:0] nxt_rdData;
  wire       wr;

  assign wr = regWrEn;
  assign liveStat = {5'h00, detNow};

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lenCtrl_ff   <= `T1LC_RST_REG;
      spareCtrl_ff <= `T1LC_RST_REG;
      spareHi_ff   <= `T1LC_RST_REG;
      spareLo_ff   <= `T1LC_RST_REG;
      upHi_ff      <= `T1LC_RST_REG;
      upLo_ff      <= `T1LC_RST_REG;
      downHi_ff    <= `T1LC_RST_REG;
      downLo_ff    <= `T1LC_RST_REG;
      irqMask_ff   <= `T1LC_RST_REG;
      txCtrl3_ff   <= `T1LC_RST_REG;
      txCtrl4_ff   <= `T1LC_RST_REG;
      txHi_ff      <= `T1LC_RST_REG;
      txLo_ff      <= `T1LC_RST_REG;
    end else if (wr) begin
      case (regAddr)
        `T1LC_OFS_RX_LEN_CTRL:   lenCtrl_ff <= regWrData;
        `T1LC_OFS_RX_SPARE_CTRL: spareCtrl_ff <= regWrData;
        `T1LC_OFS_RX_SPARE_HI:   spareHi_ff <= regWrData;
        `T1LC_OFS_RX_SPARE_LO:   spareLo_ff <= regWrData;
        `T1LC_OFS_RX_UP_HI:      upHi_ff <= regWrData;
        `T1LC_OFS_RX_UP_LO:      upLo_ff <= regWrData;
        `T1LC_OFS_RX_DOWN_HI:    downHi_ff <= regWrData;
        `T1LC_OFS_RX_DOWN_LO:    downLo_ff <= regWrData;
        `T1LC_OFS_RX_IRQ_MASK:   irqMask_ff <= regWrData;
        `T1LC_OFS_TX_CTRL3:      txCtrl3_ff <= regWrData;
        `T1LC_OFS_TX_CTRL4:      txCtrl4_ff <= regWrData;
        `T1LC_OFS_TX_CODE_HI:    txHi_ff <= regWrData;
        `T1LC_OFS_TX_CODE_LO:    txLo_ff <= regWrData;
        default: ;
      endcase
    end
  end

  always @* begin
    case (regAddr)
      `T1LC_OFS_RX_LEN_CTRL:   nxt_rdData = lenCtrl_ff;
      `T1LC_OFS_RX_LATCHED:    nxt_rdData = latched_ff;
      `T1LC_OFS_RX_SPARE_CTRL: nxt_rdData = spareCtrl_ff;
      `T1LC_OFS_RX_SPARE_HI:   nxt_rdData = spareHi_ff;
      `T1LC_OFS_RX_SPARE_LO:   nxt_rdData = spareLo_ff;
      `T1LC_OFS_RX_IRQ_MASK:   nxt_rdData = irqMask_ff;
      `T1LC_OFS_RX_UP_HI:      nxt_rdData = upHi_ff;
      `T1LC_OFS_RX_UP_LO:      nxt_rdData = upLo_ff;
      `T1LC_OFS_RX_DOWN_HI:    nxt_rdData = downHi_ff;
      `T1LC_OFS_RX_DOWN_LO:    nxt_rdData = downLo_ff;
      `T1LC_OFS_RX_LIVE:       nxt_rdData = liveStat;
      `T1LC_OFS_TX_CTRL3:      nxt_rdData = txCtrl3_ff;
      `T1LC_OFS_TX_CTRL4:      nxt_rdData = txCtrl4_ff;
      `T1LC_OFS_TX_CODE_HI:    nxt_rdData = txHi_ff;
      `T1LC_OFS_TX_CODE_LO:    nxt_rdData = txLo_ff;
      default:                 nxt_rdData = 8'h00;
    endcase
  end

  // read data valid only in the cycle after the strobe
  always @(posedge clk_sys or posedge rst) begin
    if (rst)
      rdData_ff <= 8'h00;
    else if (regRdEn)
      rdData_ff <= nxt_rdData;
    else
      rdData_ff <= 8'h00;
  end

  assign regRdData = rdData_ff;

  // ----------------------------------------
  // latched status and interrupt
  // ----------------------------------------
  wire [7:0] evt;
  wire [7:0] clrMask;

  assign evt = {2'b00, detPrev_ff & ~detNow, detNow & ~detPrev_ff};
  assign clrMask = (wr && regAddr == `T1LC_OFS_RX_LATCHED)
                   ? regWrData : 8'h00;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      detPrev_ff <= 3'h0;
      latched_ff <= `T1LC_RST_REG;
      irq_ff     <= 1'b0;
    end else begin
      detPrev_ff <= detNow;
      // set wins over a same-cycle clear
      latched_ff <= (latched_ff & ~clrMask) | evt;
      irq_ff     <= |(latched_ff & irqMask_ff);
    end
  end

  assign irqOut = irq_ff;

  // ----------------------------------------
  // generator
  // ----------------------------------------
  reg [3:0] txPh_ff;
  reg [7:0] txFrm_ff;
  reg       txBit_ff;
  reg       txAct_ff;
  wire      sendOn;
  wire      fOverwrite;
  wire [3:0] txM1;

  assign sendOn = t1Mode & txCtrl3_ff[`T1LC_BIT_SEND_EN];
  assign txM1 = txLenM1({txCtrl4_ff[`T1LC_BIT_LEN_SEL1],
                         txCtrl4_ff[`T1LC_BIT_LEN_SEL0]});
  assign fOverwrite = (txFrm_ff == 8'h00)
                      & ~txCtrl4_ff[`T1LC_BIT_FBIT_OFF];

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      txPh_ff  <= 4'h0;
      txFrm_ff <= 8'h00;
      txBit_ff <= 1'b0;
      txAct_ff <= 1'b0;
    end else begin
      txAct_ff <= sendOn;
      if (txBitEn) begin
        if (txFrm_ff == `T1LC_FRAME_BITS - 8'd1)
          txFrm_ff <= 8'h00;
        else
          txFrm_ff <= txFrm_ff + 8'd1;
      end
      if (!sendOn) begin
        txPh_ff  <= 4'h0;
        txBit_ff <= 1'b0;
      end else if (txBitEn) begin
        // overwritten pattern bit is lost, phase still moves
        txPh_ff <= nextPh(txPh_ff, txM1);
        if (fOverwrite)
          txBit_ff <= txFbit;
        else
          txBit_ff <= codeBit({txHi_ff, txLo_ff}, txM1, txPh_ff);
      end
    end
  end

  assign txLineBit = txBit_ff;
  assign txCodeActive = txAct_ff;

  // ----------------------------------------
  // detectors
  // ----------------------------------------
  wire [47:0] codeAll;
  wire [8:0]  selAll;
  wire [2:0]  restart;

  assign codeAll = {spareHi_ff, spareLo_ff, downHi_ff, downLo_ff,
                    upHi_ff, upLo_ff};
  assign selAll = {spareCtrl_ff[`T1LC_FLD_SPARE_LEN],
                   lenCtrl_ff[`T1LC_FLD_DOWN_LEN],
                   lenCtrl_ff[`T1LC_FLD_UP_LEN]};
  assign restart[0] = wr && regAddr == `T1LC_OFS_RX_UP_LO;
  assign restart[1] = wr && regAddr == `T1LC_OFS_RX_DOWN_LO;
  assign restart[2] = wr && regAddr == `T1LC_OFS_RX_SPARE_LO;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : det_g
      // two phase guesses: a holds on f slots, b moves on them
      reg [3:0]  phA_ff;
      reg [3:0]  phB_ff;
      reg [8:0]  errA_ff;
      reg [8:0]  errB_ff;
      reg [8:0]  blk_ff;
      reg        good_ff;
      reg        det_ff;
      reg [21:0] integ_ff;
      wire [15:0] code;
      wire [3:0]  m1;
      wire        misA;
      wire        misB;
      wire        cmp;
      wire [8:0]  totA;
      wire [8:0]  totB;
      wire        okA;
      wire        okB;

      assign code = codeAll[gi*16 +: 16];
      assign m1 = rxLenM1(selAll[gi*3 +: 3]);
      assign cmp = ~rxFbitSlot;
      assign misA = cmp & (rxBit ^ codeBit(code, m1, phA_ff));
      assign misB = cmp & (rxBit ^ codeBit(code, m1, phB_ff));
      assign totA = errA_ff + {8'h00, misA};
      assign totB = errB_ff + {8'h00, misB};
      assign okA = totA <= `T1LC_ERR_MAX;
      assign okB = totB <= `T1LC_ERR_MAX;

      always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          phA_ff   <= 4'h0;
          phB_ff   <= 4'h0;
          errA_ff  <= 9'h000;
          errB_ff  <= 9'h000;
          blk_ff   <= 9'h000;
          good_ff  <= 1'b0;
          det_ff   <= 1'b0;
          integ_ff <= 22'h000000;
        end else if (!t1Mode || restart[gi]) begin
          phA_ff   <= 4'h0;
          phB_ff   <= 4'h0;
          errA_ff  <= 9'h000;
          errB_ff  <= 9'h000;
          blk_ff   <= 9'h000;
          good_ff  <= 1'b0;
          det_ff   <= 1'b0;
          integ_ff <= 22'h000000;
        end else begin
          if (good_ff && !det_ff) begin
            if (integ_ff == INTEG_LAST)
              det_ff <= 1'b1;
            else
              integ_ff <= integ_ff + 22'd1;
          end
          if (rxBitEn) begin
            if (blk_ff == `T1LC_BLK_BITS - 9'd1) begin
              blk_ff  <= 9'h000;
              errA_ff <= 9'h000;
              errB_ff <= 9'h000;
              if (okA) begin
                // track a must hold when the last bit is an f slot
                good_ff <= 1'b1;
                phA_ff  <= cmp ? nextPh(phA_ff, m1) : phA_ff;
                phB_ff  <= cmp ? nextPh(phA_ff, m1) : phA_ff;
              end else if (okB) begin
                good_ff <= 1'b1;
                phA_ff  <= nextPh(phB_ff, m1);
                phB_ff  <= nextPh(phB_ff, m1);
              end else begin
                // slip one bit and restart integration
                good_ff  <= 1'b0;
                det_ff   <= 1'b0;
                integ_ff <= 22'h000000;
              end
            end else begin
              blk_ff  <= blk_ff + 9'd1;
              errA_ff <= totA;
              errB_ff <= totB;
              if (cmp)
                phA_ff <= nextPh(phA_ff, m1);
              phB_ff <= nextPh(phB_ff, m1);
            end
          end
        end
      end

      assign detNow[gi] = det_ff;
    end
  endgenerate

endmodule
`default_nettype wire

// >>> t1lc_line_model.sv
// far-end line equipment sending a repeating loop code
`default_nettype none
module t1lc_line_model (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [15:0] code,
  input  wire logic [4:0]  codeLen,
  output var  logic        rxBitEn,
  output var  logic        rxBit,
  output var  logic        rxFbitSlot
);
  timeunit 1ns;
  timeprecision 1ps;
  int   ph;
  int   slot;
  logic fVal;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rxBitEn <= 1'b0;
      rxBit <= 1'b0;
      rxFbitSlot <= 1'b0;
      ph <= 0;
      slot <= 0;
      fVal <= 1'b0;
    end else if (!rxBitEn) begin
      rxBitEn <= 1'b1;
      rxFbitSlot <= (slot == 0);
      slot <= (slot == 192) ? 0 : slot + 1;
      if (slot == 0) begin
        rxBit <= fVal;
        fVal <= ~fVal;
      end else begin
        rxBit <= code[15 - ph] ^ (slot == 100);
        ph <= (ph + 1 >= codeLen) ? 0 : ph + 1;
      end
    end else begin
      rxBitEn <= 1'b0;
      // line between bit times carries no stale value
      rxBit <= ~rxBit;
    end
  end
endmodule
`default_nettype wire

// >>> t1lc_loop_code_monitor.sv
// assertions on the ports of the loop code block
`default_nettype none
module t1lc_loop_code_monitor #(
  parameter [31:0] INTEG_CYCLES = 32'd2400000
) (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic [8:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWrEn,
  input wire logic       regRdEn,
  input wire logic [7:0] regRdData,
  input wire logic       irqOut,
  input wire logic       t1Mode,
  input wire logic       txBitEn,
  input wire logic       txFbit,
  input wire logic       txLineBit,
  input wire logic       txCodeActive,
  input wire logic       rxBitEn,
  input wire logic       rxBit,
  input wire logic       rxFbitSlot
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] maskSh_ff;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  always @(posedge clk_sys or posedge rst)
    if (rst)
      maskSh_ff <= 8'h00;
    else if (regWrEn && regAddr == 9'h0a2)
      maskSh_ff <= regWrData;
  live_width_a: assert property (
    regRdEn && regAddr == 9'h0b2 |=> regRdData[7:3] == 5'h00)
    else $error("live status upper bits set");
  latch_width_a: assert property (
    regRdEn && regAddr == 9'h092 |=> regRdData[7:6] == 2'h0)
    else $error("latched status upper bits set");
  mode_gate_a: assert property (
    txCodeActive |-> $past(t1Mode))
    else $error("code active outside t1 mode");
  send_off_a: assert property (
    regWrEn && regAddr == 9'h183 && !regWrData[0] |-> ##2 !txCodeActive)
    else $error("code still active after send cleared");
  send_on_a: assert property (
    regWrEn && regAddr == 9'h183 && regWrData[0] && t1Mode ##1 t1Mode
    |=> txCodeActive) else $error("code not active after send set");
  tx_refused_a: assert property (
    !t1Mode && txBitEn |=> !txLineBit)
    else $error("line bit sent outside t1 mode");
  irq_mask_a: assert property (
    irqOut |-> $past(maskSh_ff) != 8'h00)
    else $error("interrupt with all bits masked");
  irq_clear_a: assert property (
    regWrEn && regAddr == 9'h092 && regWrData == 8'hff |-> ##2 !irqOut)
    else $error("interrupt stays after clearing all");
  lo_restart_a: assert property (
    regWrEn && regAddr == 9'h09d ##[4:6] regRdEn && regAddr == 9'h0b2
    |=> !regRdData[2]) else $error("spare detect kept after restart");
  cover property (irqOut);
  cover property (txCodeActive && txBitEn);
  cover property (regRdEn && regAddr == 9'h0b2 ##1 regRdData[2]);
endmodule
bind t1lc_loop_code t1lc_loop_code_monitor
  #(.INTEG_CYCLES(INTEG_CYCLES)) mon (.*);
`default_nettype wire

// >>> tb.sv
// self-checking bench of the loop code block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int INTEG = 2000;
  logic        clk_sys = 1'b0, rst = 1'b1, txBitEn = 1'b0, txFbit = 1'b0;
  logic [8:0]  regAddr;
  logic [7:0]  regWrData, regRdData, v;
  logic        regWrEn, regRdEn, irqOut, t1Mode, txLineBit, txCodeActive;
  logic        rxBitEn, rxBit, rxFbitSlot, capOn, txEnD, fD, fvD;
  logic [15:0] code;
  logic [4:0]  codeLen;
  logic [31:0] seed = 32'h7c84;
  logic        qB[$], qF[$], qV[$];
  logic [7:0]  regModel[int];
  int          fail_count = 0, n_compared = 0, cyc = 0, txCnt = 0, t0;
  logic [8:0]  rwA[13] = '{9'h082, 9'h09b, 9'h09c, 9'h09d, 9'h0a2, 9'h0ac,
    9'h0ad, 9'h0ae, 9'h0af, 9'h183, 9'h186, 9'h1ac, 9'h1ad};
  t1lc_loop_code #(.INTEG_CYCLES(INTEG)) dut (.*);
  t1lc_line_model line (.*);
  always #10 clk_sys = ~clk_sys;
  function automatic logic [31:0] lfsrStep(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    seed <= lfsrStep(seed);
    txBitEn <= (cyc % 3 == 0);
    txFbit <= seed[0];
    txEnD <= txBitEn;
    fD <= (txCnt == 0);
    fvD <= txFbit;
    if (rst)
      txCnt <= 0;
    else if (txBitEn)
      txCnt <= (txCnt == 192) ? 0 : txCnt + 1;
    if (txEnD && capOn) begin
      qB.push_back(txLineBit);
      qF.push_back(fD);
      qV.push_back(fvD);
    end
    if (cyc == 60000) begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [8:0] a, logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    regModel[a] = d;
    @(posedge clk_sys);
    regWrEn <= 1'b0;
  endtask
  task automatic rd(logic [8:0] a);
    @(posedge clk_sys);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk_sys);
    regRdEn <= 1'b0;
    #1 v = regRdData;
  endtask
  task automatic rdChk(logic [8:0] a, logic [7:0] e);
    rd(a);
    chk($sformatf("reg %h", a), e, v);
  endtask
  task automatic txRun(logic [2:0] c4, int len);
    bit ok, good;
    logic [15:0] pat;
    pat = 16'hb23c;
    wr(9'h186, {5'h00, c4});
    wr(9'h1ac, pat[15:8]);
    wr(9'h1ad, pat[7:0]);
    wr(9'h183, 8'h01);
    repeat (20) @(posedge clk_sys);
    qB.delete();
    qF.delete();
    qV.delete();
    capOn <= 1'b1;
    repeat (600) @(posedge clk_sys);
    capOn <= 1'b0;
    ok = 0;
    for (int p = 0; p < len; p++) begin
      good = 1;
      foreach (qB[i])
        if (qF[i] && !c4[2])
          good &= (qB[i] === qV[i]);
        else
          good &= (qB[i] === pat[15 - (i + p) % len]);
      ok |= good;
    end
    chk("tx pattern", 1, ok);
    wr(9'h183, 8'h00);
    repeat (12) @(posedge clk_sys);
    chk("tx idle", 0, txLineBit);
  endtask
  task automatic rxStep(logic [15:0] c, logic [4:0] n, int b, logic [7:0] l);
    v = 8'h00;
    code <= c;
    codeLen <= n;
    t0 = cyc;
    for (int k = 0; k < 300 && v[b] !== 1'b1; k++) begin
      repeat (60) @(posedge clk_sys);
      rd(9'h0b2);
    end
    chk("detect time", 1, cyc - t0 >= INTEG);
    rdChk(9'h0b2, 8'(1 << b));
    rdChk(9'h092, l);
    chk("irq", (l & regModel[9'h0a2]) != 8'h00, irqOut);
    wr(9'h092, 8'hff);
  endtask
  initial begin
    {regAddr, regWrData, regWrEn, regRdEn, code, capOn} = '0;
    t1Mode = 1'b1;
    codeLen = 5'd5;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    foreach (rwA[i]) rdChk(rwA[i], 8'h00);
    rdChk(9'h092, 8'h00);
    foreach (rwA[i]) wr(rwA[i], seed[7:0]);
    foreach (rwA[i]) rdChk(rwA[i], regModel[rwA[i]]);
    wr(9'h0b2, 8'hff);
    rdChk(9'h0b2, 8'h00);
    rdChk(9'h000, 8'h00);
    for (int i = 0; i < 5; i++)
      txRun(i < 4 ? 3'(i) : 3'd7, i < 3 ? i + 5 : 16);
    wr(9'h183, 8'h01);
    t1Mode <= 1'b0;
    repeat (12) @(posedge clk_sys);
    chk("mode off", 0, {txLineBit, txCodeActive});
    t1Mode <= 1'b1;
    wr(9'h183, 8'h00);
    wr(9'h082, 8'h14);
    wr(9'h09b, 8'h07);
    wr(9'h0ac, 8'h80);
    wr(9'h0ad, 8'h00);
    wr(9'h0ae, 8'h20);
    wr(9'h0af, 8'h00);
    wr(9'h09c, 8'ha5);
    wr(9'h09d, 8'h3c);
    wr(9'h0a2, 8'h3f);
    wr(9'h092, 8'hff);
    rxStep(16'h8000, 5'd5, 0, 8'h01);
    wr(9'h0ad, 8'h00);
    rdChk(9'h0b2, 8'h00);
    wr(9'h092, 8'h00);
    rdChk(9'h092, 8'h08);
    chk("irq set", 1, irqOut);
    wr(9'h0a2, 8'h00);
    repeat (3) @(posedge clk_sys);
    chk("irq masked", 0, irqOut);
    wr(9'h0a2, 8'h30);
    wr(9'h092, 8'h08);
    rxStep(16'h8000, 5'd5, 0, 8'h01);
    rxStep(16'h2000, 5'd3, 1, 8'h0a);
    v = 8'h00;
    rxStep(16'ha53c, 5'd16, 2, 8'h14);
    wr(9'h09d, 8'h3c);
    repeat (2) @(posedge clk_sys);
    rdChk(9'h0b2, 8'h00);
    wrap_up();
  end
endmodule
`default_nettype wire
